//--- rtl/remote_command_link.sv
// Purpose: remote command link over serial line or usb byte stream
// Assumes: core consumes command bytes and supplies replies
// Notes: replies are only taken after a complete command

`timescale 1ns/1ns

// Behaviour
// - serial rate 9600, 38400, 115200; 115200 default
// - frame: start, eight data, no parity, stop
// - half duplex, never send while receiving; input is taken again once the lf is queued, while cr and lf may still go out
// - transmit only in answer to a command
// - ignore incoming msb, clear outgoing msb
// - commands delimited by hash and asterisk
// - command length set by delimiter only
// - every reply ends carriage return, line feed
// - optional rts/cts flow control both directions
// - same syntax and format on both ports
// - detect active port, reply through it
// - query: question mark, code, asterisk, answered
module remote_command_link import link_pkg::*; (
    input wire logic ref_clk, // system clock, 10 MHz
    input wire logic nrst, // synchronous reset, active low
    input wire logic [1:0] baud_sel, // serial rate select
    input wire logic flow_en, // enable rts/cts pacing
    input wire logic rxd, // serial data in
    output logic txd, // serial data out
    input wire logic cts_n, // host clear to send, active low
    output logic rts_n, // we accept data, active low
    input wire logic usb_rx_valid, // usb byte present
    input wire logic [7:0] usb_rx_data, // usb byte in
    output logic usb_rx_ready, // usb byte taken
    output logic usb_tx_valid, // usb byte out present
    output logic [7:0] usb_tx_data, // usb byte out
    input wire logic usb_tx_ready, // usb byte out taken
    output logic cmd_valid, // command byte to core
    output logic [7:0] cmd_data, // command byte
    output logic cmd_first, // byte is a start delimiter
    output logic cmd_last, // byte is an end delimiter
    output logic cmd_query, // current command is a query
    output logic cmd_port, // port of current command, 1 usb
    input wire logic cmd_ready, // core took command byte
    input wire logic rep_valid, // reply byte from core
    input wire logic [7:0] rep_data, // reply byte
    input wire logic rep_last, // last reply byte
    input wire logic rep_skip, // command needs no reply
    output logic rep_ready, // reply byte taken
    output logic link_busy // a command or reply is open
);

    // ************************************************************
    // serial ends
    // ************************************************************
    byte_if ser_rx();
    byte_if ser_tx();

    logic [1:0] baud_q, baud_d;
    logic [10:0] bit_cyc;

    always_comb begin
        unique case (baud_q)
            BAUD_SEL_MID: bit_cyc = BIT_CYC_MID;
            BAUD_SEL_SLOW: bit_cyc = BIT_CYC_SLOW;
            default: bit_cyc = BIT_CYC_FAST;
        endcase
    end

    uart_rx u_rx (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .bit_cyc(bit_cyc),
        .rxd(rxd),
        .rx(ser_rx.src)
    );

    uart_tx u_tx (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .bit_cyc(bit_cyc),
        .cts_hold(flow_en && cts_n),
        .tx(ser_tx.snk),
        .txd(txd)
    );

    // ************************************************************
    // link state
    // ************************************************************
    link_state_t state_q, state_d;
    port_t port_q, port_d;
    logic cmd_valid_q, cmd_valid_d;
    logic [7:0] cmd_data_q, cmd_data_d;
    logic cmd_first_q, cmd_first_d;
    logic cmd_last_q, cmd_last_d;
    logic query_q, query_d;
    logic after_start_q, after_start_d;
    logic out_valid_q, out_valid_d;
    logic [7:0] out_data_q, out_data_d;
    logic rts_n_q, rts_n_d;

    logic listening;
    logic sel_usb;
    logic in_valid;
    logic [7:0] in_data;
    logic in_take;
    logic cmd_free;
    logic sink_ready;
    logic out_free;

    assign listening = (state_q == LK_IDLE) || (state_q == LK_COLLECT);
    // while idle the serial port wins a tie; the losing usb byte is drained and dropped
    assign sel_usb = (state_q == LK_IDLE) ? !ser_rx.valid : (port_q == PORT_USB);
    assign in_valid = sel_usb ? usb_rx_valid : ser_rx.valid;
    assign in_data = (sel_usb ? usb_rx_data : ser_rx.data) & ASCII_MASK;
    assign cmd_free = !cmd_valid_q || cmd_ready;
    assign in_take = in_valid && listening && cmd_free;
    // bytes from the unused port, or while replying, are drained and dropped
    assign ser_rx.ready = !listening || sel_usb || cmd_free;
    assign usb_rx_ready = !listening || !sel_usb || cmd_free;

    assign sink_ready = (port_q == PORT_USB) ? usb_tx_ready : ser_tx.ready;
    assign out_free = !out_valid_q || sink_ready;
    assign rep_ready = (state_q == LK_REPLY) && out_free;

    always_comb begin
        state_d = state_q;
        port_d = port_q;
        baud_d = baud_q;
        cmd_valid_d = cmd_valid_q && !cmd_ready;
        cmd_data_d = cmd_data_q;
        cmd_first_d = cmd_first_q;
        cmd_last_d = cmd_last_q;
        query_d = query_q;
        after_start_d = after_start_q;
        out_valid_d = out_valid_q && !sink_ready;
        out_data_d = out_data_q;
        // rate changes only between exchanges with the transmitter idle, so no sent frame is cut; a frame being received can be
        if (state_q == LK_IDLE && !out_valid_q && ser_tx.ready) begin
            baud_d = (baud_sel == BAUD_SEL_MID || baud_sel == BAUD_SEL_SLOW) ? baud_sel : BAUD_SEL_FAST;
        end
        unique case (state_q)
            LK_IDLE: begin
                if (in_take && in_data == CHAR_START) begin
                    port_d = sel_usb ? PORT_USB : PORT_SERIAL;
                    state_d = LK_COLLECT;
                end
            end
            LK_COLLECT: begin
                if (in_take && in_data == CHAR_END) begin
                    state_d = LK_REPLY;
                end
            end
            LK_REPLY: begin
                if (rep_skip && !rep_valid) begin
                    state_d = LK_IDLE;
                end else if (rep_valid && out_free) begin
                    out_valid_d = 1'b1;
                    out_data_d = rep_data & ASCII_MASK;
                    if (rep_last) begin
                        state_d = LK_TERM_CR;
                    end
                end
            end
            LK_TERM_CR: begin
                if (out_free) begin
                    out_valid_d = 1'b1;
                    out_data_d = CHAR_CR;
                    state_d = LK_TERM_LF;
                end
            end
            LK_TERM_LF: begin
                if (out_free) begin
                    out_valid_d = 1'b1;
                    out_data_d = CHAR_LF;
                    state_d = LK_IDLE;
                end
            end
            default: begin
                state_d = LK_IDLE;
            end
        endcase
        // command bytes go to the core as they come; no length is assumed
        if (in_take && (state_q == LK_COLLECT || in_data == CHAR_START)) begin
            cmd_valid_d = 1'b1;
            cmd_data_d = in_data;
            cmd_first_d = (in_data == CHAR_START);
            cmd_last_d = (in_data == CHAR_END) && (state_q == LK_COLLECT);
            after_start_d = (in_data == CHAR_START);
            if (in_data == CHAR_START) begin
                query_d = 1'b0;
            end else if (after_start_q) begin
                query_d = (in_data == CHAR_QUERY);
            end
        end
        // pause the host while the core holds a byte; no receive buffer here
        rts_n_d = flow_en && !cmd_free;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= LK_IDLE;
            port_q <= PORT_SERIAL;
            baud_q <= BAUD_SEL_RESET;
            cmd_valid_q <= 1'b0;
            cmd_data_q <= 8'h00;
            cmd_first_q <= 1'b0;
            cmd_last_q <= 1'b0;
            query_q <= 1'b0;
            after_start_q <= 1'b0;
            out_valid_q <= 1'b0;
            out_data_q <= 8'h00;
            rts_n_q <= 1'b0;
        end else begin
            state_q <= state_d;
            port_q <= port_d;
            baud_q <= baud_d;
            cmd_valid_q <= cmd_valid_d;
            cmd_data_q <= cmd_data_d;
            cmd_first_q <= cmd_first_d;
            cmd_last_q <= cmd_last_d;
            query_q <= query_d;
            after_start_q <= after_start_d;
            out_valid_q <= out_valid_d;
            out_data_q <= out_data_d;
            rts_n_q <= rts_n_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign ser_tx.valid = out_valid_q && (port_q == PORT_SERIAL);
    assign ser_tx.data = out_data_q;
    assign usb_tx_valid = out_valid_q && (port_q == PORT_USB);
    assign usb_tx_data = out_data_q;
    assign cmd_valid = cmd_valid_q;
    assign cmd_data = cmd_data_q;
    assign cmd_first = cmd_first_q;
    assign cmd_last = cmd_last_q;
    assign cmd_query = query_q;
    assign cmd_port = port_q;
    assign rts_n = rts_n_q;
    assign link_busy = (state_q != LK_IDLE) || out_valid_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_baud_after_reset: assert property ($rose(nrst) |-> baud_q == BAUD_SEL_FAST)
        else $error("rate not fast after reset");
    a_no_rx_while_send: assert property ((state_q == LK_REPLY || state_q == LK_TERM_CR) |-> !in_take)
        else $error("byte accepted while replying");
    a_idle_stays_quiet: assert property ((state_q == LK_IDLE && !out_valid_q) |=> !out_valid_q)
        else $error("unsolicited transmission");
    a_msb_cleared: assert property ((out_valid_q || cmd_valid_q) |-> !out_data_q[7] && !cmd_data_q[7])
        else $error("msb not cleared");
    a_start_opens: assert property ((state_q == LK_IDLE && in_take && in_data == CHAR_START)
        |=> state_q == LK_COLLECT && cmd_first_q && cmd_data_q == CHAR_START)
        else $error("start delimiter not taken");
    a_end_closes: assert property ((state_q == LK_COLLECT && in_take && in_data == CHAR_END)
        |=> state_q == LK_REPLY && cmd_last_q && cmd_valid_q)
        else $error("end delimiter did not close command");
    a_cr_then_lf: assert property ((state_q == LK_TERM_LF && out_free)
        |-> out_data_q == CHAR_CR ##1 out_data_q == CHAR_LF && out_valid_q)
        else $error("reply not ended by cr lf");
    a_rts_follows: assert property ((flow_en && cmd_valid_q && !cmd_ready) |=> rts_n_q)
        else $error("rts not withdrawn while stalled");
    a_route_port: assert property ((usb_tx_valid |-> port_q == PORT_USB) and (ser_tx.valid |-> port_q == PORT_SERIAL))
        else $error("reply on wrong port");
    a_query_flag: assert property ((after_start_q && in_take && state_q == LK_COLLECT && in_data == CHAR_QUERY)
        |=> query_q)
        else $error("query not flagged");
    a_restart_partial: assert property ((state_q == LK_COLLECT && in_take && in_data == CHAR_START)
        |=> state_q == LK_COLLECT && cmd_first_q && !query_q)
        else $error("partial command not restarted");

    c_command_done: cover property (state_q == LK_COLLECT ##1 state_q == LK_REPLY);
    c_usb_reply: cover property (usb_tx_valid && usb_tx_ready && out_data_q == CHAR_LF);
    c_serial_reply: cover property (ser_tx.valid && ser_tx.ready && out_data_q == CHAR_LF);
    c_restart: cover property (state_q == LK_COLLECT && in_take && in_data == CHAR_START);
endmodule

//--- rtl/link_pkg.sv
// Purpose: shared constants and types of the remote command link
// Assumes: 10 MHz system clock
// Notes: bit periods are rounded to the nearest clock

package link_pkg;

    // ************************************************************
    // clock and bit rates
    // ************************************************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BAUD_FAST = 115200;
    localparam int unsigned BAUD_MID = 38400;
    localparam int unsigned BAUD_SLOW = 9600;
    localparam logic [10:0] BIT_CYC_FAST = 11'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);
    localparam logic [10:0] BIT_CYC_MID = 11'((CLK_HZ + BAUD_MID / 2) / BAUD_MID);
    localparam logic [10:0] BIT_CYC_SLOW = 11'((CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW);

    // rate select codes; the unused code falls back to the fast rate
    localparam logic [1:0] BAUD_SEL_FAST = 2'h0;
    localparam logic [1:0] BAUD_SEL_MID = 2'h1;
    localparam logic [1:0] BAUD_SEL_SLOW = 2'h2;
    localparam logic [1:0] BAUD_SEL_RESET = BAUD_SEL_FAST;

    // ************************************************************
    // character codes
    // ************************************************************
    localparam logic [7:0] CHAR_START = 8'h23;
    localparam logic [7:0] CHAR_END = 8'h2A;
    localparam logic [7:0] CHAR_QUERY = 8'h3F;
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [7:0] CHAR_LF = 8'h0A;
    localparam logic [7:0] ASCII_MASK = 8'h7F;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic {
        PORT_SERIAL = 1'b0,
        PORT_USB = 1'b1
    } port_t;

    typedef enum logic [1:0] {
        FR_IDLE = 2'h0,
        FR_START = 2'h1,
        FR_DATA = 2'h3,
        FR_STOP = 2'h2
    } frame_state_t;

    typedef enum logic [2:0] {
        LK_IDLE = 3'h0,
        LK_COLLECT = 3'h1,
        LK_REPLY = 3'h3,
        LK_TERM_CR = 3'h2,
        LK_TERM_LF = 3'h6
    } link_state_t;

endpackage

//--- rtl/byte_if.sv
// Purpose: one byte with valid and ready between link modules
// Assumes: transfer when valid and ready are both high
// Notes: none

`timescale 1ns/1ns

interface byte_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

//--- rtl/uart_rx.sv
// Purpose: serial receiver, start, eight data bits, stop
// Assumes: rxd synchronous to ref_clk
// Notes: a byte with a low stop bit is dropped

`timescale 1ns/1ns

module uart_rx import link_pkg::*; (
    input wire logic ref_clk, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic [10:0] bit_cyc, // clocks per bit
    input wire logic rxd, // serial line in
    byte_if.src rx // received byte
);
    frame_state_t state_q, state_d;
    logic [10:0] cnt_q, cnt_d;
    logic [2:0] idx_q, idx_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] data_q, data_d;
    logic valid_q, valid_d;
    logic tick;

    assign tick = (cnt_q >= bit_cyc - 11'h001);
    assign rx.valid = valid_q;
    assign rx.data = data_q;

    always_comb begin
        state_d = state_q;
        cnt_d = tick ? 11'h000 : cnt_q + 11'h001;
        idx_d = idx_q;
        sh_d = sh_q;
        data_d = data_q;
        valid_d = valid_q && !rx.ready;
        unique case (state_q)
            FR_IDLE: begin
                cnt_d = 11'h000;
                if (!rxd) begin
                    state_d = FR_START;
                end
            end
            FR_START: begin
                // realign to mid-bit so later samples sit in the eye
                if (cnt_q >= {1'b0, bit_cyc[10:1]}) begin
                    cnt_d = 11'h000;
                    idx_d = 3'h0;
                    state_d = rxd ? FR_IDLE : FR_DATA;
                end
            end
            FR_DATA: begin
                if (tick) begin
                    sh_d = {rxd, sh_q[7:1]};
                    idx_d = idx_q + 3'h1;
                    if (idx_q == 3'h7) begin
                        state_d = FR_STOP;
                    end
                end
            end
            FR_STOP: begin
                if (tick) begin
                    state_d = FR_IDLE;
                    if (rxd) begin
                        valid_d = 1'b1;
                        data_d = sh_q;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= FR_IDLE;
            cnt_q <= 11'h000;
            idx_q <= 3'h0;
            sh_q <= 8'h00;
            data_q <= 8'h00;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            sh_q <= sh_d;
            data_q <= data_d;
            valid_q <= valid_d;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_stop_gates_byte: assert property ($rose(valid_q) |-> $past(state_q) == FR_STOP && $past(rxd))
        else $error("byte delivered without a high stop bit");
    a_byte_held: assert property ((valid_q && !rx.ready && !(state_q == FR_STOP && tick)) |=> valid_q)
        else $error("unconsumed byte lost");
endmodule

//--- rtl/uart_tx.sv
// Purpose: serial transmitter, start, eight data bits, stop
// Assumes: bit_cyc stable during a frame
// Notes: cts_hold only delays the next start bit, never a frame

`timescale 1ns/1ns

module uart_tx import link_pkg::*; (
    input wire logic ref_clk, // system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic [10:0] bit_cyc, // clocks per bit
    input wire logic cts_hold, // far side not clear to send
    byte_if.snk tx, // byte to send
    output logic txd // serial line out
);
    frame_state_t state_q, state_d;
    logic [10:0] cnt_q, cnt_d;
    logic [2:0] idx_q, idx_d;
    logic [7:0] sh_q, sh_d;
    logic txd_q, txd_d;
    logic tick;

    assign tick = (cnt_q >= bit_cyc - 11'h001);
    assign tx.ready = (state_q == FR_IDLE) && !cts_hold;
    assign txd = txd_q;

    always_comb begin
        state_d = state_q;
        cnt_d = tick ? 11'h000 : cnt_q + 11'h001;
        idx_d = idx_q;
        sh_d = sh_q;
        unique case (state_q)
            FR_IDLE: begin
                cnt_d = 11'h000;
                if (tx.valid && tx.ready) begin
                    sh_d = tx.data;
                    state_d = FR_START;
                end
            end
            FR_START: begin
                if (tick) begin
                    idx_d = 3'h0;
                    state_d = FR_DATA;
                end
            end
            FR_DATA: begin
                if (tick) begin
                    sh_d = {1'b0, sh_q[7:1]};
                    idx_d = idx_q + 3'h1;
                    if (idx_q == 3'h7) begin
                        state_d = FR_STOP;
                    end
                end
            end
            FR_STOP: begin
                if (tick) begin
                    state_d = FR_IDLE;
                end
            end
        endcase
        txd_d = (state_d == FR_START) ? 1'b0 : (state_d == FR_DATA) ? sh_d[0] : 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= FR_IDLE;
            cnt_q <= 11'h000;
            idx_q <= 3'h0;
            sh_q <= 8'h00;
            txd_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            sh_q <= sh_d;
            txd_q <= txd_d;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_stop_line_high: assert property (state_q == FR_STOP |-> txd_q)
        else $error("stop bit not high");
    a_cts_blocks: assert property ((state_q == FR_IDLE && cts_hold) |=> state_q == FR_IDLE)
        else $error("frame started while clear to send was withdrawn");
endmodule

//--- testbench/host_model.sv
// Purpose: serial host that sends command frames and collects reply frames
// Assumes: bit_cyc matches the rate selected in the device
// Notes: the host holds its line high between frames

`timescale 1ns/1ns

module host_model import link_pkg::*; (
    input wire logic ref_clk, // system clock
    input wire logic [10:0] bit_cyc, // clocks per bit
    input wire logic txd, // device serial out
    output logic rxd // device serial in
);
    // ************************************************************
    // frames both ways
    // ************************************************************
    logic [7:0] got_q[$];
    logic bad_stop = 1'b0;
    logic [7:0] sh;
    initial rxd = 1'b1;

    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        wait (txd === 1'b1);
        for (int i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (bit_cyc) @(posedge ref_clk);
        end
    endtask

    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge ref_clk);
            sh[i] = txd;
        end
        repeat (bit_cyc) @(posedge ref_clk);
        if (txd !== 1'b1) bad_stop = 1'b1;
        got_q.push_back(sh);
    end
endmodule

//--- testbench/test_remote_command_link.sv
// Purpose: scenario bench of the remote command link
// Assumes: host model on the serial pins, usb and core sides driven here
// Notes: serial runs only at the fast and slow rates to keep the run short

`timescale 1ns/1ns

module test_remote_command_link import link_pkg::*; ;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] baud_sel = 2'h0;
    logic flow_en = 1'b0;
    logic cts_n = 1'b0;
    logic cmd_ready = 1'b1;
    logic usb_rx_valid = 1'b0;
    logic [7:0] usb_rx_data = 8'h00;
    logic usb_tx_ready = 1'b1;
    logic rep_valid = 1'b0;
    logic [7:0] rep_data = 8'h00;
    logic rep_last = 1'b0;
    logic rep_skip = 1'b0;
    logic [10:0] bit_cyc = BIT_CYC_FAST;
    logic rxd, txd, rts_n, usb_rx_ready, usb_tx_valid, cmd_valid, cmd_first, cmd_last;
    logic cmd_query, cmd_port, rep_ready, link_busy;
    logic [7:0] usb_tx_data, cmd_data;
    logic [11:0] cmd_q[$];
    logic [7:0] usb_q[$];
    int n_mismatch = 0;
    int num_checks = 0;

    remote_command_link i_remote_command_link (.ref_clk, .nrst, .baud_sel, .flow_en, .rxd, .txd,
        .cts_n, .rts_n, .usb_rx_valid, .usb_rx_data, .usb_rx_ready, .usb_tx_valid, .usb_tx_data,
        .usb_tx_ready, .cmd_valid, .cmd_data, .cmd_first, .cmd_last, .cmd_query, .cmd_port,
        .cmd_ready, .rep_valid, .rep_data, .rep_last, .rep_skip, .rep_ready, .link_busy);
    host_model i_host_model (.ref_clk, .bit_cyc, .txd, .rxd);

    always #50 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (cmd_valid && cmd_ready) cmd_q.push_back({cmd_port, cmd_query, cmd_first, cmd_last, cmd_data});
        if (usb_tx_valid && usb_tx_ready) usb_q.push_back(usb_tx_data);
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic usb_send(input logic [7:0] s[$]);
        foreach (s[i]) begin
            usb_rx_valid <= 1'b1;
            usb_rx_data <= s[i];
            @(negedge ref_clk);
            for (int k = 0; k < 4000 && usb_rx_ready !== 1'b1; k++) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        usb_rx_valid <= 1'b0;
    endtask

    task automatic reply(input logic [7:0] b);
        rep_valid <= 1'b1;
        rep_data <= b;
        rep_last <= 1'b1;
        @(negedge ref_clk);
        for (int k = 0; k < 4000 && rep_ready !== 1'b1; k++) @(negedge ref_clk);
        @(posedge ref_clk);
        rep_valid <= 1'b0;
        rep_last <= 1'b0;
    endtask

    task automatic check_cmds(input logic [7:0] s[$], input logic [1:0] pq);
        logic [7:0] b;
        chk("cmd count", 12'(s.size()), 12'(cmd_q.size()));
        foreach (s[i]) begin
            b = s[i] & ASCII_MASK;
            if (i < cmd_q.size()) chk("cmd byte", {2'h0, b == CHAR_START, b == CHAR_END, b}, {2'h0, cmd_q[i][9:0]});
        end
        if (cmd_q.size() > 0) chk("port query", 12'(pq), 12'(cmd_q[cmd_q.size() - 1][11:10]));
        cmd_q.delete();
    endtask

    task automatic check_q(input string what, input logic [7:0] e[$], input logic [7:0] g[$]);
        chk(what, 12'(e.size()), 12'(g.size()));
        foreach (e[i]) if (i < g.size()) chk(what, 12'(e[i]), 12'(g[i]));
    endtask

    task automatic finish_skip;
        rep_skip <= 1'b1;
        cyc(3);
        rep_skip <= 1'b0;
        cyc(3);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        @(negedge ref_clk);
        chk("txd", 12'h001, 12'(txd));
        chk("rts_n", 12'h000, 12'(rts_n));
        chk("cmd_valid", 12'h000, 12'(cmd_valid));
        chk("link_busy", 12'h000, 12'(link_busy));
        $display("test reset done");
        cyc(1);
    endtask

    task automatic t_unsolicited;
        rep_valid <= 1'b1;
        rep_data <= 8'h55;
        usb_send('{8'h41});
        cyc(20);
        @(negedge ref_clk);
        chk("rep_ready", 12'h000, 12'(rep_ready));
        chk("cmd count", 12'h000, 12'(cmd_q.size()));
        chk("usb out", 12'h000, 12'(usb_q.size()));
        cyc(2);
        rep_valid <= 1'b0;
        $display("test unsolicited done");
    endtask

    task automatic t_usb_query;
        usb_send('{8'h23, 8'h3F, 8'hC1, 8'h2A});
        cyc(5);
        check_cmds('{8'h23, 8'h3F, 8'hC1, 8'h2A}, 2'h3);
        usb_tx_ready <= 1'b0;
        reply(8'hC5);
        cyc(3);
        chk("usb held", 12'h001, 12'(usb_tx_valid));
        usb_tx_ready <= 1'b1;
        cyc(10);
        check_q("usb reply", '{8'h45, CHAR_CR, CHAR_LF}, usb_q);
        chk("serial out", 12'h000, 12'(i_host_model.got_q.size()));
        chk("link_busy", 12'h000, 12'(link_busy));
        usb_q.delete();
        $display("test usb query done");
    endtask

    task automatic t_serial;
        i_host_model.send(8'h23);
        i_host_model.send(8'h3F);
        i_host_model.send(8'h58);
        i_host_model.send(8'h2A);
        cyc(5);
        check_cmds('{8'h23, 8'h3F, 8'h58, 8'h2A}, 2'h1);
        flow_en <= 1'b1;
        cts_n <= 1'b1;
        reply(8'hDA);
        cyc(200);
        chk("cts hold", 12'h001, 12'(txd));
        cts_n <= 1'b0;
        cyc(3000);
        check_q("serial reply", '{8'h5A, CHAR_CR, CHAR_LF}, i_host_model.got_q);
        chk("stop bit", 12'h000, 12'(i_host_model.bad_stop));
        chk("usb out", 12'h000, 12'(usb_q.size()));
        i_host_model.got_q.delete();
        $display("test serial done");
    endtask

    task automatic t_restart;
        flow_en <= 1'b1;
        cmd_ready <= 1'b0;
        usb_send('{8'h23});
        cyc(3);
        chk("rts_n held", 12'h001, 12'(rts_n));
        cmd_ready <= 1'b1;
        cyc(3);
        chk("rts_n free", 12'h000, 12'(rts_n));
        usb_send('{8'h41, 8'h23, 8'h3F, 8'h42, 8'h2A});
        cyc(5);
        check_cmds('{8'h23, 8'h41, 8'h23, 8'h3F, 8'h42, 8'h2A}, 2'h3);
        finish_skip();
        chk("skip out", 12'h000, 12'(usb_q.size()));
        chk("link_busy", 12'h000, 12'(link_busy));
        flow_en <= 1'b0;
        $display("test restart done");
    endtask

    task automatic t_slow;
        baud_sel <= BAUD_SEL_SLOW;
        bit_cyc <= BIT_CYC_SLOW;
        cyc(2);
        i_host_model.send(8'h23);
        i_host_model.send(8'h2A);
        cyc(5);
        check_cmds('{8'h23, 8'h2A}, 2'h0);
        finish_skip();
        $display("test slow rate done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #8000000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        cyc(16);
        nrst <= 1'b1;
        cyc(1);
        t_reset();
        t_unsolicited();
        t_usb_query();
        t_serial();
        t_restart();
        t_slow();
        wrap_up();
    end
endmodule
